// *** shared/fcs_pkg.sv ***
// package: constants, enums and pin bundle of the flash command sequencer host
package fcs_pkg;
    localparam int CLK_MHZ = 20;
    localparam int T_AS_NS = 20;
    localparam int T_WP_NS = 60;
    localparam int T_ACC_NS = 100;
    localparam int T_REC_NS = 20;
    localparam int T_WHRL_NS = 100;

    function automatic logic [7:0] ns2cyc(input int ns);
        return 8'((ns * CLK_MHZ + 999) / 1000);
    endfunction

    localparam logic [7:0] AS_CYC = ns2cyc(T_AS_NS);
    localparam logic [7:0] WP_CYC = ns2cyc(T_WP_NS);
    localparam logic [7:0] ACC_CYC = ns2cyc(T_ACC_NS);
    localparam logic [7:0] REC_CYC = ns2cyc(T_REC_NS);
    localparam logic [7:0] WHRL_CYC = ns2cyc(T_WHRL_NS);

    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;

    localparam int SR_READY = 7;
    localparam int SR_SUSPENDED = 6;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_WRITE_ERR = 4;
    localparam int SR_SUPPLY_FAULT = 3;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;

    localparam int CTRL_GO = 8;
    localparam int CTRL_NOWAIT = 9;
    localparam int CTRL_PD_N = 16;
    localparam logic [31:0] CTRL_MASK = 32'h0007_020F;
    localparam logic [31:0] CTRL_RESET = 32'h0001_0000;
    localparam logic [31:0] ADDR_MASK = 32'h000F_FFFF;
    localparam logic [31:0] WDATA_MASK = 32'h0000_00FF;
    localparam int ST_REFUSED = 2;

    localparam logic [1:0] SUPPLY_LOW = 2'h0;
    localparam logic [1:0] SUPPLY_HIGH = 2'h1;
    localparam logic [1:0] SUPPLY_MID = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        OP_READ_ARRAY, OP_READ_ID, OP_READ_STATUS, OP_CLEAR,
        OP_ERASE, OP_WRITE, OP_SUSPEND, OP_RESUME
    } fcs_op_e;

    typedef enum logic [2:0] {K_WCMD, K_WDATA, K_READ, K_WAIT, K_END} fcs_kind_e;

    typedef enum {ST_IDLE, ST_LOAD, ST_SETUP, ST_STROBE, ST_RECOVER, ST_WAIT} fcs_state_e;

    typedef struct packed {
        logic [19:0] addr;
        logic [7:0] dq_o;
        logic dq_oe_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fcs_pins_s;
endpackage

// *** verilog/fcs_host.sv ***
// host controller that issues command sequences to the flash over its parallel pins
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module fcs_host
    import fcs_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output fcs_pins_s flash_o,
    input wire logic [7:0] flash_dq_i,
    input wire logic ready_busy_output,
    output logic powerdown_input_n,
    output logic [1:0] supply_level
);
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    // the step list of each operation; every operation opens with its command byte
    function automatic fcs_kind_e step_kind(input fcs_op_e op, input logic [2:0] step);
        fcs_kind_e k;
        k = K_END;
        case (op)
            OP_READ_ARRAY, OP_READ_ID, OP_READ_STATUS, OP_RESUME:
                k = (step == 3'h0) ? K_WCMD : (step == 3'h1) ? K_READ : K_END;
            OP_CLEAR:
                k = (step == 3'h0) ? K_WCMD : K_END;
            OP_ERASE, OP_WRITE:
                k = (step == 3'h0) ? K_WCMD : (step == 3'h1) ? ((op == OP_ERASE) ? K_WCMD : K_WDATA)
                  : (step == 3'h2) ? K_WAIT : (step == 3'h3) ? K_READ : K_END;
            OP_SUSPEND:
                k = (step == 3'h0) ? K_WCMD : (step == 3'h1) ? K_WAIT
                  : (step == 3'h2) ? K_READ : K_END;
            default: k = K_END;
        endcase
        return k;
    endfunction

    function automatic logic [7:0] cmd_byte(input fcs_op_e op, input logic [2:0] step);
        logic [7:0] c;
        case (op)
            OP_READ_ARRAY: c = CMD_READ_ARRAY;
            OP_READ_ID: c = CMD_IDENT;
            OP_READ_STATUS: c = CMD_READ_STATUS;
            OP_CLEAR: c = CMD_CLEAR_STATUS;
            OP_ERASE: c = (step == 3'h0) ? CMD_ERASE_SETUP : CMD_CONFIRM;
            OP_WRITE: c = CMD_WRITE_SETUP;
            OP_SUSPEND: c = CMD_SUSPEND;
            OP_RESUME: c = CMD_CONFIRM;
            default: c = CMD_READ_ARRAY;
        endcase
        return c;
    endfunction

    logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q, rdata_bus_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] ctrl_q, addr_q, wbyte_q;
    logic [7:0] rdata_q, cnt_q;
    logic [2:0] step_q;
    logic busy_q, refused_q, fault_q, susp_q, erase_act_q, write_act_q;
    fcs_state_e st_q;
    fcs_op_e op_q;
    fcs_kind_e kind_q, kind_w;
    fcs_pins_s pins_q;
    logic do_write, go, go_ok, reads_status, sample_now, status_sample, clear_done;
    fcs_op_e op_req;
    logic [7:0] wa, ra;

    assign wa = 8'(awaddr_q);
    assign ra = 8'(s_axi_araddr);
    assign do_write = aw_got_q && w_got_q && !bvalid_q;
    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready = !w_got_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_bus_q;
    assign flash_o = pins_q;
    assign powerdown_input_n = ctrl_q[CTRL_PD_N];
    assign supply_level = ctrl_q[CTRL_PD_N+2:CTRL_PD_N+1];
    assign op_req = fcs_op_e'(wdata_q[3:0]);
    assign go = do_write && wa == REG_CTRL && wstrb_q[1] && wdata_q[CTRL_GO];
    assign kind_w = step_kind(op_q, step_q);

    // refusals protect the device from sequences it would reject or misread
    always_comb
    begin
        go_ok = !busy_q;
        if ((op_req == OP_ERASE || op_req == OP_WRITE) && fault_q)
            go_ok = 1'b0;
        if (susp_q && !(op_req == OP_READ_ARRAY || op_req == OP_READ_STATUS
                        || op_req == OP_RESUME))
            go_ok = 1'b0;
        if (write_act_q && !ready_busy_output && op_req != OP_READ_STATUS)
            go_ok = 1'b0;
        if (erase_act_q && !susp_q && !ready_busy_output
            && !(op_req == OP_READ_STATUS || op_req == OP_SUSPEND))
            go_ok = 1'b0;
    end

    assign reads_status = op_q inside {OP_READ_STATUS, OP_ERASE, OP_WRITE, OP_SUSPEND, OP_RESUME};
    assign sample_now = st_q == ST_STROBE && cnt_q == 8'h01 && kind_q == K_READ;
    assign status_sample = sample_now && reads_status;
    assign clear_done = st_q == ST_LOAD && kind_w == K_END && op_q == OP_CLEAR;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            ctrl_q <= CTRL_RESET;
            addr_q <= '0;
            wbyte_q <= '0;
        end
        else
        begin
            if (do_write)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= RESP_OKAY;
                case (wa)
                    REG_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & CTRL_MASK;
                    REG_ADDR: addr_q <= merge(addr_q, wdata_q, wstrb_q) & ADDR_MASK;
                    REG_WDATA: wbyte_q <= merge(wbyte_q, wdata_q, wstrb_q) & WDATA_MASK;
                    REG_STATUS: ;
                    default: bresp_q <= RESP_SLVERR;
                endcase
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_bus_q <= '0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            case (ra)
                REG_CTRL: rdata_bus_q <= ctrl_q;
                REG_ADDR: rdata_bus_q <= addr_q;
                REG_WDATA: rdata_bus_q <= wbyte_q;
                REG_STATUS: rdata_bus_q <= {16'h0000, rdata_q, 1'b0, erase_act_q, write_act_q,
                                            susp_q, fault_q, refused_q, ready_busy_output,
                                            busy_q};
                default:
                begin
                    rdata_bus_q <= '0;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // flags: a setting event in the clearing cycle wins, except against the power-down clear, which wins over every set but leaves refused_q untouched
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            refused_q <= 1'b0;
            fault_q <= 1'b0;
            susp_q <= 1'b0;
            erase_act_q <= 1'b0;
            write_act_q <= 1'b0;
        end
        else
        begin
            if (go && !go_ok)
                refused_q <= 1'b1;
            else if (do_write && wa == REG_STATUS && wstrb_q[0] && wdata_q[ST_REFUSED])
                refused_q <= 1'b0;
            if (status_sample && flash_dq_i[SR_SUPPLY_FAULT])
                fault_q <= 1'b1;
            else if (clear_done)
                fault_q <= 1'b0;
            if (status_sample && op_q == OP_SUSPEND && flash_dq_i[SR_SUSPENDED])
                susp_q <= 1'b1;
            else if (status_sample && op_q == OP_RESUME)
                susp_q <= 1'b0;
            // set when the wait step is reached, so a nowait erase is tracked too
            if (st_q == ST_LOAD && kind_w == K_WAIT && op_q == OP_ERASE)
                erase_act_q <= 1'b1;
            else if (!busy_q && ready_busy_output && !susp_q)
                erase_act_q <= 1'b0;
            if (st_q == ST_LOAD && kind_w == K_WAIT && op_q == OP_WRITE)
                write_act_q <= 1'b1;
            else if (!busy_q && ready_busy_output)
                write_act_q <= 1'b0;
            if (!ctrl_q[CTRL_PD_N])
            begin
                susp_q <= 1'b0;
                fault_q <= 1'b0;
                erase_act_q <= 1'b0;
                write_act_q <= 1'b0;
            end
        end
    end

    // bus cycle engine; strobes always return high between cycles so status relatches
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= ST_IDLE;
            op_q <= OP_READ_ARRAY;
            kind_q <= K_END;
            step_q <= '0;
            cnt_q <= '0;
            busy_q <= 1'b0;
            rdata_q <= '0;
            pins_q <= '{addr: '0, dq_o: '0, dq_oe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                    if (go && go_ok)
                    begin
                        op_q <= op_req;
                        step_q <= '0;
                        busy_q <= 1'b1;
                        st_q <= ST_LOAD;
                    end
                ST_LOAD:
                begin
                    kind_q <= kind_w;
                    if (kind_w == K_END)
                    begin
                        busy_q <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                    else if (kind_w == K_WAIT)
                    begin
                        cnt_q <= WHRL_CYC;
                        if (ctrl_q[CTRL_NOWAIT])
                            step_q <= step_q + 3'h1;
                        else
                            st_q <= ST_WAIT;
                    end
                    else
                    begin
                        pins_q.addr <= addr_q[19:0];
                        pins_q.ce_n <= 1'b0;
                        pins_q.dq_oe_n <= (kind_w == K_READ);
                        pins_q.dq_o <= (kind_w == K_WDATA) ? wbyte_q[7:0] : cmd_byte(op_q, step_q);
                        cnt_q <= AS_CYC;
                        st_q <= ST_SETUP;
                    end
                end
                ST_SETUP:
                    if (cnt_q <= 8'h01)
                    begin
                        pins_q.we_n <= (kind_q == K_READ);
                        pins_q.oe_n <= (kind_q != K_READ);
                        cnt_q <= (kind_q == K_READ) ? ACC_CYC : WP_CYC;
                        st_q <= ST_STROBE;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                ST_STROBE:
                    if (cnt_q <= 8'h01)
                    begin
                        if (kind_q == K_READ)
                            rdata_q <= flash_dq_i;
                        pins_q.we_n <= 1'b1;
                        pins_q.oe_n <= 1'b1;
                        pins_q.ce_n <= 1'b1;
                        cnt_q <= REC_CYC;
                        st_q <= ST_RECOVER;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                ST_RECOVER:
                    if (cnt_q <= 8'h01)
                    begin
                        pins_q.dq_oe_n <= 1'b1; // data held past the rising strobe
                        step_q <= step_q + 3'h1;
                        st_q <= ST_LOAD;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                ST_WAIT:
                    // settle first, so the old high level of ready_busy_output is not taken
                    if (cnt_q > 8'h01)
                        cnt_q <= cnt_q - 8'h01;
                    else if (ready_busy_output)
                    begin
                        step_q <= step_q + 3'h1;
                        st_q <= ST_LOAD;
                    end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule // fcs_host

// *** dv/fcs_host_asserts.sv ***
// checker of the flash pins and axi answer channels of the host
`timescale 1ns/1ns
module fcs_host_asserts
    import fcs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire fcs_pins_s flash_o
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved early");
    wr_drive_a: assert property (!flash_o.we_n |-> !flash_o.dq_oe_n && !flash_o.ce_n)
        else $error("write strobe without driven data");
    rd_float_a: assert property (!flash_o.oe_n |-> flash_o.dq_oe_n && !flash_o.ce_n)
        else $error("read strobe while host drives data");
    rd_pulse_a: assert property ($fell(flash_o.oe_n) |-> !flash_o.oe_n [*2] ##1 flash_o.oe_n)
        else $error("read strobe length wrong");
    wr_pulse_a: assert property ($fell(flash_o.we_n) |-> !flash_o.we_n [*2] ##1 flash_o.we_n)
        else $error("write strobe length wrong");
    wr_setup_a: assert property ($fell(flash_o.we_n) |-> !$past(flash_o.ce_n))
        else $error("select not set up before write strobe");
    wr_hold_a: assert property (!flash_o.we_n |-> $stable(flash_o.addr) && $stable(flash_o.dq_o))
        else $error("address or data moved under write strobe");
    rd_gap_a: assert property ($rose(flash_o.oe_n) |=> flash_o.oe_n && flash_o.we_n)
        else $error("no strobe gap after a read");
endmodule // fcs_host_asserts

// *** dv/fcs_flash_model.sv ***
// behavioural flash device answering the host pins
`timescale 1ns/1ns
module fcs_flash_model
    import fcs_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
    parameter logic [7:0] PART_ID = 8'hC3, // arbitrary value
    parameter int OP_TICKS = 200
)(
    input wire fcs_pins_s pins,
    input wire logic powerdown_input_n,
    input wire logic [1:0] supply_level, // intermediate taken as high
    output logic [7:0] dq,
    output logic ready_busy_output
);
    logic [7:0] mem [int];
    logic [7:0] lat = 8'h00;
    logic [7:0] c;
    logic [2:0] err = 3'b000;
    int mode = 0;
    int pend = 0;
    int busy = 0;
    bit erasing = 0;
    bit susp = 0;
    bit sreq = 0;
    logic [7:0] sr;
    logic wr_on;
    assign wr_on = !pins.we_n && !pins.ce_n;
    assign sr = {busy == 0 || susp, susp, err, 3'b000};
    assign ready_busy_output = busy == 0 || susp || !powerdown_input_n;
    // a released bus shows the inverse so stale data cannot pass as a read
    assign dq = (!pins.ce_n && !pins.oe_n) ? lat : ~lat;
    always @(negedge pins.oe_n or negedge pins.ce_n)
        if (!pins.oe_n && !pins.ce_n)
            lat = mode == 2 ? sr : mode == 1 ? (pins.addr[0] ? PART_ID : MAKER_ID) :
                (mem.exists(pins.addr) ? mem[pins.addr] : 8'hFF);
    // a write ends at whichever of the two strobes rises first
    always @(negedge wr_on)
        if (powerdown_input_n)
        begin
            c = pins.dq_o;
            if (pend == 2)
            begin
                pend = 0;
                mode = 2;
                if (supply_level == SUPPLY_LOW)
                    err[0] = 1'b1;
                else
                begin
                    mem[pins.addr] = c & (mem.exists(pins.addr) ? mem[pins.addr] : 8'hFF);
                    busy = OP_TICKS;
                    erasing = 0;
                end
            end
            else if (pend == 1)
            begin
                pend = 0;
                mode = 2;
                if (c != CMD_CONFIRM)
                    err[2:1] = 2'b11;
                else if (supply_level == SUPPLY_LOW)
                    err[0] = 1'b1;
                else
                begin
                    busy = OP_TICKS;
                    erasing = 1;
                    foreach (mem[k])
                        if (k[19:16] == pins.addr[19:16])
                            mem[k] = 8'hFF;
                end
            end
            else if (susp)
            begin
                if (c == CMD_READ_ARRAY) mode = 0;
                if (c == CMD_READ_STATUS) mode = 2;
                if (c == CMD_CONFIRM) {susp, mode} = {1'b0, 32'd2};
            end
            else if (busy > 0)
            begin
                if (c == CMD_READ_STATUS) mode = 2;
                if (c == CMD_SUSPEND && erasing) sreq = 1;
            end
            else
                case (c)
                    CMD_READ_ARRAY: mode = 0;
                    CMD_IDENT: mode = 1;
                    CMD_READ_STATUS: mode = 2;
                    CMD_CLEAR_STATUS: err = 3'b000;
                    CMD_ERASE_SETUP: pend = 1;
                    CMD_WRITE_SETUP: pend = 2;
                    default: ;
                endcase
        end
    always
    begin
        #50;
        if (!powerdown_input_n)
            {busy, susp, sreq, pend, err, mode} = '0;
        else if (busy > 0 && supply_level == SUPPLY_LOW)
            {busy, susp, err[0]} = {32'd0, 2'b01};
        else if (sreq)
            {susp, sreq} = 2'b10;
        else if (busy > 0 && !susp)
            busy--;
    end
endmodule // fcs_flash_model

// *** dv/fcs_host_bench.sv ***
// testbench of the flash host: axi master, device model and expected status bytes
`timescale 1ns/1ns
bind fcs_host fcs_host_asserts i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .flash_o(flash_o));
module fcs_host_bench
    import fcs_pkg::*;
;
    localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
    localparam logic [7:0] PART = 8'hE5; // arbitrary value
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, dq;
    logic [31:0] wdata = 0, rdata, rd_d, a, d;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp, rd_r, wr_r, sup, sup_v = SUPPLY_LOW;
    logic awready, wready, bvalid, arready, rvalid, rb, pd_n, pd_v = 1;
    logic [7:0] ref_b = 8'hFF;
    fcs_pins_s pins;
    int errors = 0, checked = 0, seed = 6, i;
    always #25 aclk = ~aclk;
    fcs_host #(.ADDR_W(8)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_o(pins),
        .flash_dq_i(dq), .ready_busy_output(rb), .powerdown_input_n(pd_n), .supply_level(sup));
    fcs_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART), .OP_TICKS(200)) i_dev (.pins(pins),
        .powerdown_input_n(pd_n), .supply_level(sup), .dq(dq), .ready_busy_output(rb));
    task automatic print_verdict;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] s);
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {ad, dt, s};
        {awvalid, wvalid, bready} <= 3'b111;
        forever
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                wr_r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] ad);
        @(posedge aclk);
        araddr <= ad;
        {arvalid, rready} <= 2'b11;
        forever
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                {rd_d, rd_r} = {rdata, rresp};
                rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic ctrl(input logic [3:0] o, input logic nw, input logic g);
        axi_wr(REG_CTRL, {13'h0, sup_v, pd_v, 6'h0, nw, g, 4'h0, o}, 4'hF);
    endtask
    // start an order and poll until the sequencer is idle again
    task automatic op(input logic [3:0] o, input logic nw);
        ctrl(o, nw, 1'b1);
        do axi_rd(REG_STATUS); while (rd_d[0] !== 1'b0);
    endtask
    function automatic logic [7:0] sb(input logic r, s, e, w, f);
        return {r, s, e, w, f, 3'b000};
    endfunction
    initial
    begin
        repeat (60000) @(posedge aclk);
        errors++;
        print_verdict;
    end
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(REG_CTRL);
        chk(rd_d, CTRL_RESET);
        chk({pd_n, sup}, {1'b1, SUPPLY_LOW});
        for (i = 0; i < 2; i++)
        begin
            axi_wr(REG_ADDR, i, 4'hF);
            op(OP_READ_ID, 0);
            chk(rd_d[15:8], i ? PART : MAKER);
        end
        op(OP_READ_STATUS, 0);
        chk(rd_d[15:8], sb(1, 0, 0, 0, 0));
        op(OP_ERASE, 0);
        chk(rd_d[15:8], sb(1, 0, 0, 0, 1));
        op(OP_ERASE, 0);
        chk(rd_d[ST_REFUSED], 1);
        axi_wr(REG_STATUS, 32'h0000_0004, 4'h1);
        op(OP_CLEAR, 0);
        op(OP_READ_STATUS, 0);
        chk(rd_d[15:0], {sb(1, 0, 0, 0, 0), 8'h02});
        sup_v = SUPPLY_HIGH;
        a = $random(seed) & ADDR_MASK;
        axi_wr(REG_ADDR, a, 4'hF);
        for (i = 0; i < 2; i++)
        begin
            d = $random(seed) & WDATA_MASK;
            ref_b = ref_b & d[7:0];
            axi_wr(REG_WDATA, d, 4'hF);
            op(OP_WRITE, 0);
            chk(rd_d[15:8], sb(1, 0, 0, 0, 0));
            op(OP_READ_ARRAY, 0);
            chk(rd_d[15:8], ref_b);
        end
        op(OP_ERASE, 0);
        chk(rd_d[15:8], sb(1, 0, 0, 0, 0));
        ref_b = 8'hFF;
        op(OP_READ_ARRAY, 0);
        chk(rd_d[15:8], ref_b);
        op(OP_ERASE, 1);
        op(OP_WRITE, 0);
        chk(rd_d[ST_REFUSED], 1);
        axi_wr(REG_STATUS, 32'h0000_0004, 4'h1);
        op(OP_SUSPEND, 0);
        chk({rd_d[15:8], rd_d[4], rb}, {sb(1, 1, 0, 0, 0), 2'b11});
        axi_wr(REG_ADDR, a ^ 32'h0001_0000, 4'hF);
        op(OP_READ_ARRAY, 0);
        chk(rd_d[15:8], ref_b);
        op(OP_RESUME, 0);
        chk({rd_d[15:8], rd_d[4], rb}, {sb(0, 0, 0, 0, 0), 2'b00});
        do op(OP_READ_STATUS, 0); while (rd_d[15] !== 1'b1);
        chk(rd_d[15:8], sb(1, 0, 0, 0, 0));
        for (i = 0; i < 2; i++)
        begin
            sup_v = SUPPLY_HIGH;
            op(i ? OP_WRITE : OP_ERASE, 1);
            sup_v = SUPPLY_LOW;
            ctrl(0, 0, 0);
            repeat (4) @(posedge aclk);
            op(OP_READ_STATUS, 0);
            chk({rd_d[15:8], rb}, {sb(1, 0, 0, 0, 1), 1'b1});
            if (i == 0) op(OP_CLEAR, 0);
        end
        pd_v = 0;
        ctrl(0, 0, 0);
        repeat (4) @(posedge aclk);
        chk({pd_n, rb}, 2'b01);
        pd_v = 1;
        ctrl(0, 0, 0);
        op(OP_READ_STATUS, 0);
        chk({rd_d[15:8], rd_d[3]}, {sb(1, 0, 0, 0, 0), 1'b0});
        axi_rd(8'h10);
        chk({rd_r, rd_d}, {RESP_SLVERR, 32'h0000_0000});
        axi_wr(8'h14, 32'h0000_0001, 4'hF);
        chk(wr_r, RESP_SLVERR);
        print_verdict;
    end
endmodule // fcs_host_bench
